// ==== pkg/regbank_pkg.sv ====
// Shared constants and carrier types for the status, pin routing and
// converter select register bank.
// Assumes one 40 MHz clock and a host on the serial peripheral port.
package regbank_pkg;

  // Register offsets on the serial port address space.
  localparam logic [6:0] OFF_STATUS = 7'h35;
  localparam logic [6:0] OFF_LEVELS = 7'h36;
  localparam logic [6:0] OFF_DRIVE = 7'h37;
  localparam logic [6:0] OFF_ROUTE0 = 7'h38;
  localparam logic [6:0] OFF_ROUTE1 = 7'h39;
  localparam logic [6:0] OFF_ROUTE2 = 7'h3a;
  localparam logic [6:0] OFF_ROUTE3 = 7'h3b;
  localparam logic [6:0] OFF_CONV = 7'h3c;

  // Status register bit positions.
  localparam int BIT_STARTED = 7;
  localparam int BIT_LOCK = 6;
  localparam int BIT_SLIP = 5;
  localparam int BIT_CARRIER = 4;
  localparam int BIT_FEI = 3;

  // Converter select field positions.
  localparam int REF_MSB = 7;
  localparam int REF_LSB = 5;
  localparam int IN_MSB = 3;

  // Values after reset.
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [6:0] RST_ROUTE0 = 7'h12;
  localparam logic [6:0] RST_ROUTE1 = 7'h13;
  localparam logic [6:0] RST_ROUTE2 = 7'h34;
  localparam logic [6:0] RST_ROUTE3 = 7'h14;
  localparam logic [2:0] RST_CONV_REF = 3'h0;
  localparam logic [3:0] RST_CONV_IN = 4'h0;

  // Serial command byte: bit 7 set means write, bits 6:0 the address.
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Clocks after reset release before the start mode strap is caught.
  // The synchroniser shows its reset value for two edges, so the strap
  // is taken at the third edge.
  localparam logic [1:0] STRAP_DELAY = 2'h3;

  typedef struct packed {
    logic sclk;
    logic csn;
    logic mosi;
  } spi_pins_t;

  typedef struct packed {
    logic started_normal_flag;
    logic synth_in_lock;
    logic cycle_slip;
    logic carrier_sense_flag;
    logic freq_error_stable;
  } radio_flags_t;

  typedef struct packed {
    logic [1:0] pin_three_drive;
    logic [1:0] pin_two_drive;
    logic [1:0] pin_one_drive;
    logic [1:0] pin_zero_drive;
    logic [6:0] pin_three_route;
    logic [6:0] pin_two_route;
    logic [6:0] pin_one_route;
    logic [6:0] pin_zero_route;
  } pin_config_t;

  typedef struct packed {
    logic [2:0] reference_choice;
    logic [3:0] converter_input_choice;
  } converter_sel_t;

endpackage

// ==== core/signal_sync.sv ====
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes each level holds for more than two clock periods.
`timescale 1ns/10ps
`default_nettype none
module signal_sync #(
  parameter int WIDTH = 12
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Levels in and out.
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ==== core/spi_byte_shifter.sv ====
// Byte shifter of the serial peripheral port, mode 0, MSB first.
// Assumes synchronised, edge-detected serial clock inputs.
`timescale 1ns/10ps
`default_nettype none
module spi_byte_shifter (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Serial side.
  input wire logic select,
  input wire logic sclk_rise,
  input wire logic sclk_fall,
  input wire logic mosi,
  output var logic miso,
  // Parallel side.
  input wire logic load,
  input wire logic [7:0] load_byte,
  output var logic byte_done,
  output var logic [7:0] rx_byte
);

  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [7:0] rx_next;
  logic done_next;

  always_comb begin
    cnt_next = cnt_reg;
    tx_next = tx_reg;
    rx_next = rx_byte;
    done_next = 1'b0;
    if (!select) begin
      cnt_next = 3'h0;
    end else begin
      if (sclk_rise) begin
        rx_next = {rx_byte[6:0], mosi};
        cnt_next = cnt_reg + 3'h1;
        done_next = (cnt_reg == regbank_pkg::BIT_LAST);
      end
      // The falling edge that ends a byte must not shift the next one.
      if (sclk_fall && cnt_reg != 3'h0) begin
        tx_next = {tx_reg[6:0], 1'b0};
      end
    end
    if (load) begin
      tx_next = load_byte;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 3'h0;
      tx_reg <= 8'h00;
      rx_byte <= 8'h00;
      byte_done <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tx_reg <= tx_next;
      rx_byte <= rx_next;
      byte_done <= done_next;
    end
  end

  assign miso = tx_reg[7];

endmodule
`default_nettype wire

// ==== core/status_pin_mux_adc_select_regs.sv ====
// Status, pin level, pin drive and routing, and converter select
// registers, reached over the serial peripheral port.
// Assumes an external tri-state buffer on the data out pin, a serial
// clock of at most one eighth of the 40 MHz clock, and slip pulses
// from the synthesizer longer than two clock periods.
//
// Summary of operation
// - Status bit 7: started normal, else backup.
// - Status bit 6: live synthesizer lock.
// - Status bit 5: slip sticky, cleared by read.
// - Status bit 4: live carrier sense.
// - Status bit 3: frequency error estimate stable.
// - Unused bits of these registers read zero.
// - Pin level bits 3:0 show sampled pins.
// - Two drive bits per pin, reset zero.
// - Seven route bits per pin, pin one 0x13.
// - Pin zero route resets to 0x12.
// - Pin two 0x34, pin three 0x14.
// - Converter reference select in bits 7:5.
// - Converter input select in bits 3:0.
// - Input codes seven to thirteen kept as written.
`timescale 1ns/10ps
`default_nettype none
module status_pin_mux_adc_select_regs (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Serial peripheral port.
  input wire regbank_pkg::spi_pins_t spi_pins,
  output var logic spi_miso,
  output var logic spi_miso_oe,
  // Radio conditions and pin levels.
  input wire regbank_pkg::radio_flags_t radio_flags,
  input wire logic [3:0] pin_levels_in,
  // Settings driven to the pins and the converter.
  output var regbank_pkg::pin_config_t pin_config,
  output var regbank_pkg::converter_sel_t converter_sel
);
  import regbank_pkg::*;

  typedef enum logic [1:0] {ph_command, ph_write, ph_read} phase_t;

  // Synchronised inputs.
  spi_pins_t spi_s;
  radio_flags_t flags_s;
  logic [3:0] levels_s;

  // Chip select crosses inverted, so the synchroniser's reset value
  // reads as deselected and the data out pin stays released.
  signal_sync #(.WIDTH(12)) in_sync (
    .clock(clock),
    .resetn(resetn),
    .async_in({spi_pins.sclk, ~spi_pins.csn, spi_pins.mosi, radio_flags,
               pin_levels_in}),
    .sync_out({spi_s, flags_s, levels_s})
  );

  // Serial port control state.
  phase_t phase_reg;
  phase_t phase_next;
  logic [6:0] addr_reg;
  logic [6:0] addr_next;
  logic sclk_prev_reg;
  logic oe_next;
  logic select;
  logic sclk_rise;
  logic sclk_fall;
  logic load;
  logic [7:0] load_byte;
  logic [6:0] load_addr;
  logic byte_done;
  logic [7:0] rx_byte;
  logic write_en;

  // Status state.
  logic slip_reg;
  logic slip_next;
  logic slip_prev_reg;
  logic started_reg;
  logic started_next;
  logic [1:0] strap_cnt_reg;
  logic [1:0] strap_cnt_next;
  logic slip_event;
  logic status_read;

  // Settings state.
  logic [7:0] drive_reg;
  logic [7:0] drive_next;
  logic [6:0] route_reg [4];
  logic [6:0] route_next [4];
  converter_sel_t conv_reg;
  converter_sel_t conv_next;
  logic [1:0] route_idx;

  // Read value of any address; unmapped addresses read zero.
  function automatic logic [7:0] read_value(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      OFF_STATUS: begin
        v[BIT_STARTED] = started_reg;
        v[BIT_LOCK] = flags_s.synth_in_lock;
        v[BIT_SLIP] = slip_reg;
        v[BIT_CARRIER] = flags_s.carrier_sense_flag;
        v[BIT_FEI] = flags_s.freq_error_stable;
      end
      OFF_LEVELS: v = {4'h0, levels_s};
      OFF_DRIVE: v = drive_reg;
      OFF_ROUTE0, OFF_ROUTE1, OFF_ROUTE2, OFF_ROUTE3: begin
        v = {1'b0, route_reg[2'(a - OFF_ROUTE0)]};
      end
      // Converter select bit 4 reads zero.
      OFF_CONV: begin
        v = {conv_reg.reference_choice, 1'b0,
             conv_reg.converter_input_choice};
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  assign select = spi_s.csn;
  assign sclk_rise = spi_s.sclk & ~sclk_prev_reg;
  assign sclk_fall = ~spi_s.sclk & sclk_prev_reg;

  spi_byte_shifter shifter (
    .clock(clock),
    .resetn(resetn),
    .select(select),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .mosi(spi_s.mosi),
    .miso(spi_miso),
    .load(load),
    .load_byte(load_byte),
    .byte_done(byte_done),
    .rx_byte(rx_byte)
  );

  // Command byte picks direction and start address; the address then
  // advances by one for every data byte of a burst.
  always_comb begin
    phase_next = phase_reg;
    addr_next = addr_reg;
    load = 1'b0;
    load_addr = addr_reg;
    write_en = 1'b0;
    oe_next = select;
    if (!select) begin
      phase_next = ph_command;
    end else if (byte_done) begin
      unique case (phase_reg)
        ph_command: begin
          if (rx_byte[CMD_WRITE_BIT]) begin
            phase_next = ph_write;
            addr_next = rx_byte[6:0];
          end else begin
            phase_next = ph_read;
            load = 1'b1;
            load_addr = rx_byte[6:0];
            addr_next = rx_byte[6:0] + 7'h01;
          end
        end
        ph_write: begin
          write_en = 1'b1;
          addr_next = addr_reg + 7'h01;
        end
        ph_read: begin
          load = 1'b1;
          addr_next = addr_reg + 7'h01;
        end
      endcase
    end
  end

  // A process, so that changes of the registers read inside the
  // function also update the byte.
  always_comb begin
    load_byte = read_value(load_addr);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= ph_command;
      addr_reg <= 7'h00;
      sclk_prev_reg <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      addr_reg <= addr_next;
      sclk_prev_reg <= spi_s.sclk;
      spi_miso_oe <= oe_next;
    end
  end

  assign slip_event = flags_s.cycle_slip & ~slip_prev_reg;
  assign status_read = load && (load_addr == OFF_STATUS);

  always_comb begin
    slip_next = slip_reg;
    started_next = started_reg;
    strap_cnt_next = strap_cnt_reg;
    // Read clears the slip flag; a new slip wins.
    if (status_read) begin
      slip_next = 1'b0;
    end
    if (slip_event) begin
      slip_next = 1'b1;
    end
    // Catch the start mode once after reset.
    if (strap_cnt_reg != STRAP_DELAY) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
    end
    if (strap_cnt_reg == STRAP_DELAY - 2'h1) begin
      started_next = flags_s.started_normal_flag;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      slip_reg <= 1'b0;
      slip_prev_reg <= 1'b0;
      started_reg <= 1'b0;
      strap_cnt_reg <= 2'h0;
    end else begin
      slip_reg <= slip_next;
      slip_prev_reg <= flags_s.cycle_slip;
      started_reg <= started_next;
      strap_cnt_reg <= strap_cnt_next;
    end
  end

  assign route_idx = 2'(addr_reg - OFF_ROUTE0);

  // Read-only writes dropped.
  // Only writable fields are stored; other addresses and bits drop.
  always_comb begin
    drive_next = drive_reg;
    conv_next = conv_reg;
    for (int i = 0; i < 4; i++) begin
      route_next[i] = route_reg[i];
    end
    if (write_en) begin
      if (addr_reg == OFF_DRIVE) begin
        drive_next = rx_byte;
      end
      if (addr_reg >= OFF_ROUTE0 && addr_reg <= OFF_ROUTE3) begin
        route_next[route_idx] = rx_byte[6:0];
      end
      if (addr_reg == OFF_CONV) begin
        conv_next.reference_choice = rx_byte[REF_MSB:REF_LSB];
        conv_next.converter_input_choice = rx_byte[IN_MSB:0];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      drive_reg <= RST_DRIVE;
      route_reg[0] <= RST_ROUTE0;
      route_reg[1] <= RST_ROUTE1;
      route_reg[2] <= RST_ROUTE2;
      route_reg[3] <= RST_ROUTE3;
      conv_reg <= '{RST_CONV_REF, RST_CONV_IN};
    end else begin
      drive_reg <= drive_next;
      for (int i = 0; i < 4; i++) begin
        route_reg[i] <= route_next[i];
      end
      conv_reg <= conv_next;
    end
  end

  assign pin_config = {drive_reg, route_reg[3], route_reg[2],
                       route_reg[1], route_reg[0]};
  assign converter_sel = conv_reg;

  // Checks.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence seq_write(logic [6:0] a);
    write_en && addr_reg == a;
  endsequence

  chk_slip_read_clear: assert property (
    status_read && !slip_event |=> !slip_reg)
    else $error("slip flag not cleared by status read");

  chk_slip_event_set: assert property (
    slip_event |=> slip_reg
      && (load_addr != OFF_STATUS || load_byte[BIT_SLIP]))
    else $error("slip event not held in status");

  chk_route_reset: assert property (
    $rose(resetn) |-> route_reg[0] == 7'h12 && route_reg[1] == 7'h13
      && route_reg[2] == 7'h34 && route_reg[3] == 7'h14)
    else $error("route fields wrong after reset");

  chk_drive_write: assert property (
    seq_write(OFF_DRIVE) |=> drive_reg == $past(rx_byte))
    else $error("drive strength write lost");

  chk_ro_write_kept: assert property (
    seq_write(OFF_STATUS) or seq_write(OFF_LEVELS) |=>
      $stable(drive_reg) && $stable(conv_reg)
      && ($stable(slip_reg) || $past(slip_event)))
    else $error("read-only write disturbed state");

  chk_level_read: assert property (
    load && load_addr == OFF_LEVELS |-> load_byte == {4'h0, levels_s})
    else $error("pin level read wrong");

  chk_status_low_zero: assert property (
    status_read |-> load_byte[2:0] == 3'h0
      && load_byte[BIT_LOCK] == flags_s.synth_in_lock)
    else $error("status read wrong");

  chk_conv_write: assert property (
    seq_write(OFF_CONV) |=> converter_sel == {$past(rx_byte[7:5]),
      $past(rx_byte[3:0])} ##1 $stable(converter_sel) || write_en)
    else $error("converter select write wrong");

  chk_strap_held: assert property (
    strap_cnt_reg == STRAP_DELAY |=> $stable(started_reg))
    else $error("start mode changed after capture");

endmodule
`default_nettype wire

// ==== test/spi_host_model.sv ====
// Host side of the serial peripheral port: mode 0, MSB first, frames
// framed by chip select. Assumes the bench resolves the data out wire.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Clock.
  input wire logic clock,
  // Serial lines.
  output var regbank_pkg::spi_pins_t pins,
  input wire logic miso
);
  // Eight clocks per serial clock half, well inside the sync margin.
  localparam int HALF = 8;

  initial pins = 3'b010;

  task automatic start();
    @(negedge clock);
    pins.csn = 1'b0;
    repeat (HALF) @(negedge clock);
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins.mosi = tx[i];
      repeat (HALF) @(negedge clock);
      pins.sclk = 1'b1;
      rx[i] = miso;
      repeat (HALF) @(negedge clock);
      pins.sclk = 1'b0;
    end
  endtask

  // Outside a frame the data line shows the inverse of its last level.
  task automatic stop();
    repeat (HALF) @(negedge clock);
    pins.csn = 1'b1;
    pins.mosi = ~pins.mosi;
    repeat (HALF) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the status, pin and converter select bank.
// Assumes the host model drives the serial port at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import regbank_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  spi_pins_t spi_pins;
  logic spi_miso;
  logic spi_miso_oe;
  logic miso_line;
  logic miso_last = 1'b0;
  radio_flags_t radio_flags = 5'b10000;
  logic [3:0] pin_levels_in = 4'h0;
  pin_config_t pin_config;
  converter_sel_t converter_sel;
  logic [7:0] m [8] = '{8'h00, 8'h00, 8'h00, 8'h12, 8'h13, 8'h34, 8'h14,
    8'h00};
  logic slip_exp = 1'b0;
  int errors = 0;
  int checked = 0;

  always #12.5 clock = ~clock;
  // A released data out line shows the inverse of its last level.
  always @(posedge clock) if (spi_miso_oe) miso_last <= spi_miso;
  assign miso_line = spi_miso_oe ? spi_miso : ~miso_last;

  status_pin_mux_adc_select_regs i_dut (
    .clock(clock), .resetn(resetn), .spi_pins(spi_pins),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .radio_flags(radio_flags), .pin_levels_in(pin_levels_in),
    .pin_config(pin_config), .converter_sel(converter_sel));
  spi_host_model i_host (.clock(clock), .pins(spi_pins), .miso(miso_line));

  function automatic logic [7:0] exp_byte(input int a);
    // The start mode input was high through reset, so bit 7 stays set.
    if (a == 'h35)
      return {1'b1, radio_flags.synth_in_lock, slip_exp,
        radio_flags.carrier_sense_flag, radio_flags.freq_error_stable, 3'h0};
    if (a == 'h36)
      return {4'h0, pin_levels_in};
    if (a >= 'h37 && a <= 'h3c)
      return m[a - 'h35];
    return 8'h00;
  endfunction

  task automatic check(input string what, input logic [35:0] exp, got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_outputs();
    logic [6:0] cs;
    cs = {m[7][7:5], m[7][3:0]};
    check("drive", 36'(m[2]), 36'(pin_config[35:28]));
    for (int k = 0; k < 4; k++) begin
      check("route", 36'(m[3 + k]), 36'(pin_config[7 * k +: 7]));
    end
    check("conv", 36'(cs), 36'(converter_sel));
  endtask

  task automatic rd_burst(input int a, input int n);
    logic [7:0] rx;
    i_host.start();
    i_host.xfer(8'(a), rx);
    for (int i = 0; i < n; i++) begin
      i_host.xfer(8'h00, rx);
      check("read", 36'(exp_byte(a + i)), 36'(rx));
      if (a + i == 'h35) slip_exp = 1'b0;
    end
    check("miso_oe", 36'h1, 36'(spi_miso_oe));
    i_host.stop();
    check("miso_oe", 36'h0, 36'(spi_miso_oe));
  endtask

  task automatic wr_burst(input int a, input int n, input int fixed);
    logic [7:0] rx;
    logic [7:0] d;
    i_host.start();
    i_host.xfer(8'h80 | 8'(a), rx);
    for (int i = 0; i < n; i++) begin
      d = (fixed < 0) ? 8'($urandom) : 8'(fixed);
      i_host.xfer(d, rx);
      // Reserved and read-only bits are dropped.
      if (a + i == 'h37) m[2] = d;
      else if (a + i >= 'h38 && a + i <= 'h3b) m[a + i - 'h35] = d & 8'h7f;
      else if (a + i == 'h3c) m[7] = d & 8'hef;
    end
    i_host.stop();
  endtask

  task automatic conclude();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    conclude();
  end

  initial begin
    logic [31:0] r;
    void'($urandom(26));
    repeat (8) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    repeat (6) @(negedge clock);
    radio_flags.started_normal_flag = 1'b0;
    check_outputs();
    rd_burst('h35, 9);
    repeat (3) begin
      r = $urandom;
      radio_flags = {1'b0, r[0], 1'b0, r[1], r[2]};
      pin_levels_in = r[6:3];
      wr_burst('h35, 9, -1);
      check_outputs();
      rd_burst('h35, 8);
    end
    // Selects are written before any conversion.
    for (int c = 0; c < 16; c++) begin
      wr_burst('h3c, 1, int'({c[2:0], 1'b1, c[3:0]}));
      check_outputs();
    end
    @(negedge clock);
    radio_flags.cycle_slip = 1'b1;
    repeat (4) @(negedge clock);
    radio_flags.cycle_slip = 1'b0;
    slip_exp = 1'b1;
    rd_burst('h35, 2);
    rd_burst('h35, 1);
    rd_burst('h40, 2);
    conclude();
  end
endmodule
`default_nettype wire
